//--- src/pps_cfg.svh
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
// Register indices; the byte address of a register is four times its index.
`define PPS_IDX_ENABLE 6'h00
`define PPS_IDX_POLARITY 6'h01
`define PPS_IDX_CLKSEL 6'h02
`define PPS_IDX_PRESCALE 6'h03
`define PPS_IDX_ALIGN 6'h04
`define PPS_IDX_CONTROL 6'h05
`define PPS_IDX_TEST_A 6'h06
`define PPS_IDX_TEST_B 6'h07
`define PPS_IDX_SCALE_A 6'h08
`define PPS_IDX_SCALE_B 6'h09
// Field positions inside the pairing and low-power control register.
`define PPS_BIT_JOIN_LSB 4
`define PPS_BIT_WAIT_STOP 3
`define PPS_BIT_FREEZE_STOP 2
// Field positions inside the prescale select register.
`define PPS_PRESC_A_LSB 0
`define PPS_PRESC_B_LSB 4
// Reset value of every register.
`define PPS_REG_RESET 8'h00
// Bus answers.
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2
// Bus widths.
`define PPS_ADDR_W 8
`endif

//--- src/pps_pkg.sv
package pps_pkg;
    // Effective controls handed to one channel counter.
    typedef struct packed {
        logic enable;
        logic polarity;
        logic centerAlign;
        logic tick;
    } pps_chan_s;
    // One register byte.
    typedef logic [7:0] pps_byte_t;
    // Scale divider count, wide enough for twice 256.
    typedef logic [9:0] pps_scale_t;
    // Write channel progress.
    typedef enum logic [0:0] {WR_COLLECT, WR_RESPOND} pps_wr_e;
endpackage : pps_pkg

//--- src/pps_top.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_top
    import pps_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address and data.
    input wire logic awvalid,
    output logic awready,
    input wire logic [`PPS_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read.
    input wire logic arvalid,
    output logic arready,
    input wire logic [`PPS_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Chip operating modes, from logic on this clock.
    input wire logic waitMode,
    input wire logic freezeMode,
    // Waveforms from the channel counters.
    input wire logic [7:0] chanWave,
    input wire logic [3:0] pairWave,
    // Controls to the channel counters.
    output pps_chan_s [7:0] chanCtl,
    output logic [3:0] joinPair,
    // Modulator output port pins.
    output logic [7:0] modulatorOutputPort
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    pps_byte_t enable_r; // Channel enables.
    pps_byte_t polarity_r; // Channel polarities.
    pps_byte_t clkSel_r; // Unscaled or scaled clock per channel.
    pps_byte_t prescale_r; // Prescale selects for clocks A and B.
    pps_byte_t align_r; // Center-align per channel.
    pps_byte_t pairingAndLowpowerControl_r; // Join and low-power bits.
    pps_byte_t scaleAValue_r; // Scale value for clock A.
    pps_byte_t scaleBValue_r; // Scale value for clock B.

    // ----------------------------------------------------------------
    // Write channel state
    // ----------------------------------------------------------------
    pps_wr_e wrState_r, wrState_nxt; // Collecting or answering.
    logic awHeld_r, awHeld_nxt; // Address captured.
    logic wHeld_r, wHeld_nxt; // Data captured.
    logic [5:0] wrIdx_r; // Captured register index.
    pps_byte_t wrData_r; // Captured low data byte.
    logic wrLane_r; // Captured low byte enable.
    logic awready_r, wready_r, bvalid_r; // Handshake flops.
    logic [1:0] bresp_r; // Write answer code.

    // ----------------------------------------------------------------
    // Read channel state
    // ----------------------------------------------------------------
    logic arready_r, rvalid_r; // Handshake flops.
    logic [31:0] rdata_r; // Read data held for the master.
    logic [1:0] rresp_r; // Read answer code.

    // ----------------------------------------------------------------
    // Clock generation state
    // ----------------------------------------------------------------
    logic [6:0] presc_r; // Prescale counter, halted by the wait and freeze stops.
    pps_scale_t scaleACnt_r; // Scale A down counter.
    pps_scale_t scaleBCnt_r; // Scale B down counter.
    logic tickSA_r, tickSB_r; // Scaled clock pulses.
    logic tickA_r, tickB_r; // Prescaled clock pulses.

    // ----------------------------------------------------------------
    // Registered outputs to the channels and pins
    // ----------------------------------------------------------------
    pps_chan_s [7:0] chanCtl_r;
    logic [3:0] joinPair_r;
    logic [7:0] pin_r;

    // True when a register index is mapped.
    function automatic logic isMapped(input logic [5:0] idx);
        isMapped = (idx <= `PPS_IDX_SCALE_B);
    endfunction : isMapped

    // Divider reload value, twice the scale with zero taken as 256.
    function automatic pps_scale_t scaleLoad(input pps_byte_t v);
        scaleLoad = (v == 8'h00) ? 10'h200 : {1'b0, v, 1'b0};
    endfunction : scaleLoad

    // Prescaled tick: every sel-th power of two of the running counter.
    function automatic logic prescTick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'h7f >> (3'h7 - sel);
        prescTick = ((cnt & mask) == mask);
    endfunction : prescTick

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    wire logic awTake = awvalid & awready_r;
    wire logic wTake = wvalid & wready_r;
    wire logic wrFire = (wrState_r == WR_COLLECT) & awHeld_r & wHeld_r;
    wire logic wrDo = wrFire & wrLane_r & isMapped(wrIdx_r);
    wire logic wrDone = bvalid_r & bready;
    wire logic wrEnable = wrDo & (wrIdx_r == `PPS_IDX_ENABLE);
    wire logic wrPolarity = wrDo & (wrIdx_r == `PPS_IDX_POLARITY);
    wire logic wrClkSel = wrDo & (wrIdx_r == `PPS_IDX_CLKSEL);
    wire logic wrPrescale = wrDo & (wrIdx_r == `PPS_IDX_PRESCALE);
    wire logic wrAlign = wrDo & (wrIdx_r == `PPS_IDX_ALIGN);
    wire logic wrControl = wrDo & (wrIdx_r == `PPS_IDX_CONTROL);
    wire logic wrScaleA = wrDo & (wrIdx_r == `PPS_IDX_SCALE_A);
    wire logic wrScaleB = wrDo & (wrIdx_r == `PPS_IDX_SCALE_B);

    // Next state of the write channel.
    always_comb begin
        wrState_nxt = wrState_r;
        awHeld_nxt = awHeld_r | awTake;
        wHeld_nxt = wHeld_r | wTake;
        case (wrState_r)
            WR_COLLECT: begin
                if (wrFire) begin
                    wrState_nxt = WR_RESPOND;
                end
            end
            WR_RESPOND: begin
                if (wrDone) begin
                    wrState_nxt = WR_COLLECT;
                    awHeld_nxt = 1'b0;
                    wHeld_nxt = 1'b0;
                end
            end
            default: begin
                wrState_nxt = WR_COLLECT;
            end
        endcase
    end

    // Write handshake flops; address and data are taken in either order.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrState_r <= WR_COLLECT;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `PPS_RESP_OKAY;
        end else begin
            wrState_r <= wrState_nxt;
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            awready_r <= (wrState_nxt == WR_COLLECT) & ~awHeld_nxt;
            wready_r <= (wrState_nxt == WR_COLLECT) & ~wHeld_nxt;
            bvalid_r <= (wrState_nxt == WR_RESPOND);
            if (wrFire) begin
                bresp_r <= isMapped(wrIdx_r) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
            end
        end
    end

    // Capture of write address and data.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrIdx_r <= 6'h00;
            wrData_r <= `PPS_REG_RESET;
            wrLane_r <= 1'b0;
        end else begin
            if (awTake) begin
                wrIdx_r <= awaddr[7:2];
            end
            if (wTake) begin
                wrData_r <= wdata[7:0];
                wrLane_r <= wstrb[0];
            end
        end
    end

    // Register writes; test registers have no storage at all.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r <= `PPS_REG_RESET;
            polarity_r <= `PPS_REG_RESET;
            clkSel_r <= `PPS_REG_RESET;
            prescale_r <= `PPS_REG_RESET;
            align_r <= `PPS_REG_RESET;
            pairingAndLowpowerControl_r <= `PPS_REG_RESET;
            scaleAValue_r <= `PPS_REG_RESET;
            scaleBValue_r <= `PPS_REG_RESET;
        end else begin
            if (wrEnable) enable_r <= wrData_r;
            if (wrPolarity) polarity_r <= wrData_r;
            if (wrClkSel) clkSel_r <= wrData_r;
            if (wrPrescale) prescale_r <= wrData_r & 8'h77;
            if (wrAlign) align_r <= wrData_r;
            if (wrControl) pairingAndLowpowerControl_r <= wrData_r & 8'hfc;
            if (wrScaleA) scaleAValue_r <= wrData_r;
            if (wrScaleB) scaleBValue_r <= wrData_r;
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    wire logic [5:0] rdIdx = araddr[7:2];
    wire logic arTake = arvalid & arready_r;
    pps_byte_t rdByte;

    // Read mux; test registers and reserved bits read as zero.
    always_comb begin
        case (rdIdx)
            `PPS_IDX_ENABLE: rdByte = enable_r;
            `PPS_IDX_POLARITY: rdByte = polarity_r;
            `PPS_IDX_CLKSEL: rdByte = clkSel_r;
            `PPS_IDX_PRESCALE: rdByte = prescale_r;
            `PPS_IDX_ALIGN: rdByte = align_r;
            `PPS_IDX_CONTROL: rdByte = pairingAndLowpowerControl_r;
            `PPS_IDX_SCALE_A: rdByte = scaleAValue_r;
            `PPS_IDX_SCALE_B: rdByte = scaleBValue_r;
            default: rdByte = 8'h00;
        endcase
    end

    // Read handshake; one read under way, answered the cycle after it is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `PPS_RESP_OKAY;
        end else begin
            if (arTake) begin
                rvalid_r <= 1'b1;
                arready_r <= 1'b0;
                rdata_r <= {24'h000000, rdByte};
                rresp_r <= isMapped(rdIdx) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
            end else if (rvalid_r & rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end else begin
                arready_r <= ~rvalid_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and low-power gating
    // ----------------------------------------------------------------
    // The prescaler input is stopped in wait or freeze when asked for.
    wire logic waitHold = pairingAndLowpowerControl_r[`PPS_BIT_WAIT_STOP] & waitMode;
    wire logic freezeHold = pairingAndLowpowerControl_r[`PPS_BIT_FREEZE_STOP] & freezeMode;
    wire logic prescRun = ~(waitHold | freezeHold);
    wire logic tickA = prescRun & prescTick(presc_r, prescale_r[`PPS_PRESC_A_LSB +: 3]);
    wire logic tickB = prescRun & prescTick(presc_r, prescale_r[`PPS_PRESC_B_LSB +: 3]);
    wire logic scaleAEnd = tickA & (scaleACnt_r == 10'h001);
    wire logic scaleBEnd = tickB & (scaleBCnt_r == 10'h001);

    // Prescale counter advances only while its input clock runs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_r <= 7'h00;
        end else if (prescRun) begin
            presc_r <= presc_r + 7'h01;
        end
    end

    // Scale dividers: reload on write or at expiry, pulse once per load.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scaleACnt_r <= 10'h200;
            scaleBCnt_r <= 10'h200;
        end else begin
            if (wrScaleA) begin
                scaleACnt_r <= scaleLoad(wrData_r);
            end else if (scaleAEnd) begin
                scaleACnt_r <= scaleLoad(scaleAValue_r);
            end else if (tickA) begin
                scaleACnt_r <= scaleACnt_r - 10'h001;
            end
            if (wrScaleB) begin
                scaleBCnt_r <= scaleLoad(wrData_r);
            end else if (scaleBEnd) begin
                scaleBCnt_r <= scaleLoad(scaleBValue_r);
            end else if (tickB) begin
                scaleBCnt_r <= scaleBCnt_r - 10'h001;
            end
        end
    end

    // Clock pulses, registered so every channel sees them together.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickA_r <= 1'b0;
            tickB_r <= 1'b0;
            tickSA_r <= 1'b0;
            tickSB_r <= 1'b0;
        end else begin
            tickA_r <= tickA;
            tickB_r <= tickB;
            tickSA_r <= scaleAEnd & ~wrScaleA;
            tickSB_r <= scaleBEnd & ~wrScaleB;
        end
    end

    // ----------------------------------------------------------------
    // Channel controls and pairing
    // ----------------------------------------------------------------
    wire logic [3:0] joinBits = pairingAndLowpowerControl_r[`PPS_BIT_JOIN_LSB +: 4];
    pps_chan_s [7:0] ctlNxt;
    logic [7:0] pinNxt;

    // Channels 0,1,4,5 run from A or SA; channels 2,3,6,7 from B or SB.
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            // A joined pair takes all controls from its higher channel.
            int s;
            s = (joinBits[c / 2]) ? (c | 1) : c;
            ctlNxt[c].enable = enable_r[s];
            ctlNxt[c].polarity = polarity_r[s];
            ctlNxt[c].centerAlign = align_r[s];
            if ((c / 2) % 2 == 0) begin
                ctlNxt[c].tick = clkSel_r[s] ? tickSA_r : tickA_r;
            end else begin
                ctlNxt[c].tick = clkSel_r[s] ? tickSB_r : tickB_r;
            end
        end
        for (int p = 0; p < 4; p++) begin
            // Joined: the 16-bit wave leaves on the odd pin, even pin idles low.
            pinNxt[2 * p] = joinBits[p] ? 1'b0 : chanWave[2 * p];
            pinNxt[2 * p + 1] = joinBits[p] ? pairWave[p] : chanWave[2 * p + 1];
        end
    end

    // Output flops toward the channels and pins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chanCtl_r <= '0;
            joinPair_r <= 4'h0;
            pin_r <= 8'h00;
        end else begin
            chanCtl_r <= ctlNxt;
            joinPair_r <= joinBits;
            pin_r <= pinNxt;
        end
    end

    // ----------------------------------------------------------------
    // Port drive
    // ----------------------------------------------------------------
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign chanCtl = chanCtl_r;
    assign joinPair = joinPair_r;
    assign modulatorOutputPort = pin_r;

endmodule : pps_top

//--- bench/pps_top_assertions.sv
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_top_assertions
    import pps_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [`PPS_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [`PPS_ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    // Modes, waveforms and controls.
    input wire logic waitMode,
    input wire logic freezeMode,
    input wire logic [7:0] chanWave,
    input wire logic [3:0] pairWave,
    input wire pps_chan_s [7:0] chanCtl,
    input wire logic [3:0] joinPair,
    input wire logic [7:0] modulatorOutputPort
);
    // ----------------------------------------
    // Shadow of the low-power bits and hold counters
    // ----------------------------------------
    logic [1:0] upCnt, lpQ;
    logic [7:0] awQ, arQ, wQ;
    logic wsQ, bvQ, anyTick;
    logic [2:0] waitCnt, frzCnt;
    // Any channel tick at all.
    always_comb begin
        anyTick = 1'b0;
        for (int i = 0; i < 8; i++) anyTick = anyTick | chanCtl[i].tick;
    end
    // The shadow follows control writes as the response appears.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {upCnt, lpQ, awQ, arQ, wQ, wsQ, bvQ, waitCnt, frzCnt} <= '0;
        end else begin
            upCnt <= (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
            if (awvalid && awready) awQ <= awaddr;
            if (wvalid && wready) wQ <= wdata[7:0];
            if (wvalid && wready) wsQ <= wstrb[0];
            if (arvalid && arready) arQ <= araddr;
            bvQ <= bvalid;
            if (bvalid && !bvQ && awQ[7:2] == `PPS_IDX_CONTROL && wsQ) lpQ <= wQ[3:2];
            waitCnt <= !(lpQ[1] && waitMode) ? 3'h0 : (waitCnt == 3'h7) ? waitCnt : waitCnt + 3'h1;
            frzCnt <= !(lpQ[0] && freezeMode) ? 3'h0 : (frzCnt == 3'h7) ? frzCnt : frzCnt + 3'h1;
        end
    end
    // ----------------------------------------
    // Pair joining and pins
    // ----------------------------------------
    for (genvar p = 0; p < 4; p++) begin : g_pair
        join_even_low_a: assert property (@(posedge clk) disable iff (rst)
            joinPair[p] && $past(joinPair[p]) |-> !modulatorOutputPort[2*p])
            else $error("Even pin of a joined pair is driven.");
        join_odd_pin_a: assert property (@(posedge clk) disable iff (rst)
            joinPair[p] && $past(joinPair[p]) |-> modulatorOutputPort[2*p+1] == $past(pairWave[p]))
            else $error("Odd pin of a joined pair misses the wide waveform.");
        split_pin_a: assert property (@(posedge clk) disable iff (rst)
            upCnt == 2'h3 && !joinPair[p] && !$past(joinPair[p])
            |-> modulatorOutputPort[2*p+1 -: 2] == $past(chanWave[2*p+1 -: 2]))
            else $error("Separate channel pins do not follow their waveforms.");
        join_ctl_copy_a: assert property (@(posedge clk) disable iff (rst)
            joinPair[p] && $past(joinPair[p]) && $past(joinPair[p], 2)
            |-> chanCtl[2*p] == chanCtl[2*p+1])
            else $error("Joined pair controls differ.");
    end
    // ----------------------------------------
    // Registers and low-power holds
    // ----------------------------------------
    test_read_zero_a: assert property (@(posedge clk) disable iff (rst)
        rvalid && (arQ[7:2] == `PPS_IDX_TEST_A || arQ[7:2] == `PPS_IDX_TEST_B) |-> rdata == 32'h0)
        else $error("Test register read not zero.");
    frozen_read_a: assert property (@(posedge clk) disable iff (rst)
        freezeMode && arvalid && arready |=> rvalid)
        else $error("Read not answered in freeze.");
    frozen_write_a: assert property (@(posedge clk) disable iff (rst)
        freezeMode && awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("Write not answered in freeze.");
    wait_halt_a: assert property (@(posedge clk) disable iff (rst)
        waitCnt >= 3'h4 |-> !anyTick)
        else $error("Ticks seen while held in wait.");
    freeze_halt_a: assert property (@(posedge clk) disable iff (rst)
        frzCnt >= 3'h4 |-> !anyTick)
        else $error("Ticks seen while held in freeze.");
endmodule : pps_top_assertions

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "pps_cfg.svh"
module tb_top
    import pps_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic waitMode = 1'b0, freezeMode = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, chanWave = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0, pairWave = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    pps_chan_s [7:0] chanCtl;
    logic [3:0] joinPair;
    logic [7:0] modulatorOutputPort;
    int badCount = 0, compares = 0;
    always #25 clk = ~clk;
    pps_top u_dut (.clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .waitMode, .freezeMode, .chanWave, .pairWave, .chanCtl, .joinPair, .modulatorOutputPort);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Counts and reports one comparison.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus write; ready levels are sampled mid-cycle, where they are settled.
    task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0,
                      input logic st = 1'b1);
        logic aTk, wTk, bTk;
        logic [1:0] rsp;
        awaddr <= {ix, 2'h0};
        wdata <= {24'hc3c3c3, d};
        wstrb <= {3'h7, st};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bTk = 1'b0;
        while (!bTk) begin
            @(negedge clk);
            aTk = awvalid && awready;
            wTk = wvalid && wready;
            bTk = bvalid && bready;
            rsp = bresp;
            @(posedge clk);
            if (aTk) awvalid <= 1'b0;
            if (wTk) wvalid <= 1'b0;
        end
        chk("bresp", {30'h0, er}, {30'h0, rsp});
    endtask : wr
    // One bus read; data is compared only when an OKAY answer is expected.
    task automatic rd(input logic [5:0] ix, input logic [7:0] e, input logic [1:0] er = 2'h0);
        logic aTk, rTk;
        logic [31:0] dat;
        logic [1:0] rsp;
        araddr <= {ix, 2'h0};
        arvalid <= 1'b1;
        rTk = 1'b0;
        while (!rTk) begin
            @(negedge clk);
            aTk = arvalid && arready;
            rTk = rvalid && rready;
            dat = rdata;
            rsp = rresp;
            @(posedge clk);
            if (aTk) arvalid <= 1'b0;
        end
        chk("rresp", {30'h0, er}, {30'h0, rsp});
        if (er == `PPS_RESP_OKAY) chk("rdata", {24'h0, e}, dat);
    endtask : rd
    // Cycles to the next tick of a channel, then the gap to the one after.
    task automatic gap(input int ch, output int f, output int p);
        f = 0;
        do begin @(negedge clk); f++; end while (chanCtl[ch].tick !== 1'b1 && f < 1100);
        p = 0;
        do begin @(negedge clk); p++; end while (chanCtl[ch].tick !== 1'b1 && p < 1100);
        @(posedge clk);
    endtask : gap
    // Ticks of channel 0 over a number of cycles.
    task automatic cnt(output int c);
        c = 0;
        repeat (10) begin @(negedge clk); if (chanCtl[0].tick === 1'b1) c++; end
        @(posedge clk);
    endtask : cnt
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 10; i++) rd(i[5:0], 8'h00);
        wr(`PPS_IDX_SCALE_A, 8'h5a);
        rd(`PPS_IDX_SCALE_A, 8'h5a);
        wr(`PPS_IDX_SCALE_B, 8'ha5);
        wr(`PPS_IDX_SCALE_B, 8'h33, `PPS_RESP_OKAY, 1'b0);
        rd(`PPS_IDX_SCALE_B, 8'ha5);
        wr(`PPS_IDX_CONTROL, 8'hff);
        rd(`PPS_IDX_CONTROL, 8'hfc);
        wr(`PPS_IDX_TEST_A, 8'hff);
        rd(`PPS_IDX_TEST_A, 8'h00);
        wr(`PPS_IDX_TEST_B, 8'hff);
        rd(`PPS_IDX_TEST_B, 8'h00);
        wr(6'h0a, 8'h11, `PPS_RESP_SLVERR);
        rd(6'h0a, 8'h00, `PPS_RESP_SLVERR);
        wr(`PPS_IDX_CONTROL, 8'h00);
    endtask : t_regs
    // Joins each pair alone; odd channels enabled, even ones inverted in polarity.
    task automatic t_join;
        logic [7:0] ex;
        wr(`PPS_IDX_ENABLE, 8'haa);
        wr(`PPS_IDX_POLARITY, 8'h55);
        wr(`PPS_IDX_ALIGN, 8'haa);
        chanWave <= 8'h55;
        pairWave <= 4'hf;
        for (int p = 0; p < 4; p++) begin
            wr(`PPS_IDX_CONTROL, 8'(8'h10 << p));
            repeat (3) @(negedge clk);
            ex = (8'h55 & ~(8'h03 << 2 * p)) | (8'h02 << 2 * p);
            chk("joinPair", 32'(4'h1 << p), 32'(joinPair));
            chk("pins", 32'(ex), 32'(modulatorOutputPort));
            chk("even enable", 32'h1, 32'(chanCtl[2 * p].enable));
            chk("even polarity", 32'h0, 32'(chanCtl[2 * p].polarity));
            chk("even align", 32'h1, 32'(chanCtl[2 * p].centerAlign));
            @(posedge clk);
        end
        wr(`PPS_IDX_CONTROL, 8'h00);
        wr(`PPS_IDX_ENABLE, 8'hff);
    endtask : t_join
    // Holds the prescaler in one low-power mode and lets it go both ways.
    task automatic t_low(input int b, input logic [1:0] md);
        int c;
        wr(`PPS_IDX_CONTROL, 8'(1 << b));
        {freezeMode, waitMode} <= md;
        repeat (4) @(posedge clk);
        cnt(c);
        chk("held ticks", 32'h0, 32'(c));
        rd(`PPS_IDX_SCALE_A, 8'h5a);
        wr(`PPS_IDX_CONTROL, 8'h00);
        repeat (4) @(posedge clk);
        cnt(c);
        chk("free ticks", 32'd10, 32'(c));
        wr(`PPS_IDX_CONTROL, 8'(1 << b));
        {freezeMode, waitMode} <= 2'h0;
        repeat (4) @(posedge clk);
        cnt(c);
        chk("mode end ticks", 32'd10, 32'(c));
        wr(`PPS_IDX_CONTROL, 8'h00);
    endtask : t_low
    task automatic t_scale;
        int f, p;
        for (int s = 0; s < 8; s++) begin
            wr(`PPS_IDX_PRESCALE, 8'(s));
            // Let ticks of the old setting leave the pipeline first.
            repeat (2) @(posedge clk);
            gap(1, f, p);
            chk("clock A gap", 32'(1 << s), 32'(p));
        end
        wr(`PPS_IDX_PRESCALE, 8'h10);
        wr(`PPS_IDX_CLKSEL, 8'h05);
        wr(`PPS_IDX_SCALE_A, 8'h03);
        gap(0, f, p);
        chk("SA gap", 32'd6, 32'(p));
        wr(`PPS_IDX_SCALE_A, 8'h00);
        gap(0, f, p);
        chk("SA full gap", 32'd512, 32'(p));
        wr(`PPS_IDX_SCALE_A, 8'h03);
        gap(0, f, p);
        chk("SA reload", 32'h1, 32'(f <= 10));
        wr(`PPS_IDX_SCALE_B, 8'h02);
        gap(2, f, p);
        chk("SB gap", 32'd8, 32'(p));
        wr(`PPS_IDX_SCALE_B, 8'h00);
        gap(2, f, p);
        chk("SB full gap", 32'd1024, 32'(p));
        wr(`PPS_IDX_SCALE_B, 8'h02);
        gap(2, f, p);
        chk("SB reload", 32'h1, 32'(f <= 12));
    endtask : t_scale
    // ----------------------------------------
    // Verdict, sequence and watchdog
    // ----------------------------------------
    task automatic conclude;
        if (badCount == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_join();
        t_low(3, 2'h1);
        t_low(2, 2'h2);
        t_scale();
        conclude();
    end
    // The whole sequence needs well under ten thousand cycles.
    initial begin
        #2000000;
        badCount++;
        conclude();
    end
endmodule : tb_top
bind pps_top pps_top_assertions u_chk (.clk, .rst, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .arvalid, .arready, .araddr, .rvalid, .rdata, .waitMode,
    .freezeMode, .chanWave, .pairWave, .chanCtl, .joinPair, .modulatorOutputPort);
